//--- design/scfg_regs.svh
`ifndef SCFG_REGS_SVH
`define SCFG_REGS_SVH

// Configuration word
`define SCFG_WORD_W 14
`define SCFG_M_W 9
`define SCFG_N_W 2
`define SCFG_T_W 3
`define SCFG_M_LSB 0
`define SCFG_N_LSB 9
`define SCFG_T_LSB 11
`define SCFG_RST_M 9'h1ff
`define SCFG_RST_N 2'h3
`define SCFG_RST_T 3'h0

// Reference prescaler and loop
`define SCFG_REF_PRESCALE 16
`define SCFG_HALF_PER_M 8
`define SCFG_CREDIT_W 16

// Post-divider codes and ratios
`define SCFG_N_DIV2 2'h0
`define SCFG_N_DIV4 2'h1
`define SCFG_N_DIV8 2'h2
`define SCFG_N_DIV1 2'h3
`define SCFG_RATIO_W 4

// Serial link timing
`define SCFG_ACLK_PERIOD_NS 100
`define SCFG_SCLK_PERIOD_NS 800
`define SCFG_SCLK_HALF_CYC (`SCFG_SCLK_PERIOD_NS / (2 * `SCFG_ACLK_PERIOD_NS))

// Host register map
`define SCFG_A_CTRL 4'h0
`define SCFG_A_WORD 4'h4
`define SCFG_A_CMD 4'h8
`define SCFG_A_STATUS 4'hc
`define SCFG_CTRL_OE 0
`define SCFG_CTRL_REFSEL 1
`define SCFG_CTRL_PARDRV 2
`define SCFG_CMD_SERIAL 0
`define SCFG_CMD_PARALLEL 1
`define SCFG_RST_CTRL 3'h3
`define SCFG_RESP_OKAY 2'h0
`define SCFG_RESP_SLVERR 2'h2

`endif

//--- design/scfg_pkg.sv
package scfg_pkg;

  typedef struct packed {
    logic [2:0] probe;
    logic [1:0] post;
    logic [8:0] fbdiv;
  } scfg_word_s;

  typedef enum logic [2:0] {
    SCFG_H_IDLE = 3'b000,
    SCFG_H_SH_LO = 3'b001,
    SCFG_H_SH_HI = 3'b010,
    SCFG_H_LD_HI = 3'b011,
    SCFG_H_LD_LO = 3'b100,
    SCFG_H_PAR_LO = 3'b101,
    SCFG_H_PAR_HI = 3'b110
  } scfg_hstate_e;

  typedef enum logic [2:0] {
    SCFG_P_QUIET = 3'b000,
    SCFG_P_CMP = 3'b001,
    SCFG_P_REF = 3'b010,
    SCFG_P_VCO = 3'b011,
    SCFG_P_FOUT = 3'b100,
    SCFG_P_GATE = 3'b101,
    SCFG_P_SCLK = 3'b110,
    SCFG_P_SPARE = 3'b111
  } scfg_probe_e;

endpackage : scfg_pkg

//--- design/scfg_link_if.sv
`timescale 1ns/1ps
interface scfg_link_if;
  logic s_clock;
  logic s_data;
  logic s_load;
  logic p_load_n;
  logic [8:0] m_drv;
  logic m_oe;
  logic [1:0] n_drv;
  logic n_oe;
  logic oe;
  logic ref_source_select;
  logic [8:0] m_pin;
  logic [1:0] n_pin;
  logic fout_p;
  logic fout_n;
  logic test_out;

  // Undriven divider pins pull up to one
  assign m_pin = m_oe ? m_drv : 9'h1ff;
  assign n_pin = n_oe ? n_drv : 2'h3;

  modport host (
    output s_clock, s_data, s_load, p_load_n, m_drv, m_oe, n_drv, n_oe,
    output oe, ref_source_select,
    input fout_p, fout_n, test_out
  );
  modport dev (
    input s_clock, s_data, s_load, p_load_n, m_pin, n_pin, oe,
    input ref_source_select,
    output fout_p, fout_n, test_out
  );
endinterface : scfg_link_if

//--- design/scfg_div.sv
`timescale 1ns/1ps
module scfg_div
  import scfg_pkg::*;
#(
  parameter int DIV = 16,
  parameter int W = 5
)(
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic tick_in,
  output logic tick_out,
  output logic toggle_out
);
  logic [W-1:0] cnt_q;
  logic [W-1:0] cnt_d;
  logic tick_d;
  logic tog_d;

  // Counts input ticks, pulses once every DIV of them
  always_comb
  begin
    cnt_d = cnt_q;
    tick_d = 1'b0;
    tog_d = toggle_out;
    if (tick_in)
    begin
      if (cnt_q >= W'(DIV - 1))
      begin
        cnt_d = '0;
        tick_d = 1'b1;
        tog_d = ~toggle_out;
      end
      else
        cnt_d = cnt_q + W'(1);
    end
  end

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      cnt_q <= '0;
      tick_out <= 1'b0;
      toggle_out <= 1'b0;
    end
    else
    begin
      cnt_q <= cnt_d;
      tick_out <= tick_d;
      toggle_out <= tog_d;
    end
  end
endmodule : scfg_div

//--- design/scfg_dev.sv
`timescale 1ns/1ps
`include "scfg_regs.svh"
module scfg_dev
  import scfg_pkg::*;
(
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic xtal_clk_in,
  input wire logic alt_ref_clock_in,
  scfg_link_if.dev link
);
  localparam int SW = 19;

  logic [SW-1:0] pins_d;
  logic [SW-1:0] sync1_q;
  logic [SW-1:0] sync2_q;
  logic s_clock_s;
  logic s_data_s;
  logic s_load_s;
  logic p_load_n_s;
  logic [`SCFG_M_W-1:0] m_s;
  logic [`SCFG_N_W-1:0] n_s;
  logic oe_s;
  logic sel_s;
  logic xtal_s;
  logic alt_s;
  logic ref_s;

  logic sclk_prev_q;
  logic sload_prev_q;
  logic pload_prev_q;
  logic ref_prev_q;
  logic [`SCFG_WORD_W-1:0] shift_q;
  logic [`SCFG_WORD_W-1:0] shift_d;
  scfg_word_s cfg_q;
  scfg_word_s cfg_d;

  logic [`SCFG_CREDIT_W-1:0] credit_q;
  logic [`SCFG_CREDIT_W-1:0] credit_d;
  logic [`SCFG_RATIO_W-1:0] half_cnt_q;
  logic [`SCFG_RATIO_W-1:0] half_cnt_d;
  logic [`SCFG_RATIO_W-1:0] ratio;
  logic raw_q;
  logic raw_d;
  logic gate_q;
  logic gate_d;
  logic fout_p_d;
  logic test_d;
  logic ref_rise;
  logic cmp_tick;
  logic cmp_tog;
  logic vco_tick;

  // Pin synchroniser
  always_comb
  begin
    pins_d = {link.s_clock, link.s_data, link.s_load, link.p_load_n,
              link.m_pin, link.n_pin, link.oe, link.ref_source_select,
              xtal_clk_in, alt_ref_clock_in};
  end

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      sync1_q <= '0;
      sync2_q <= '0;
    end
    else
    begin
      sync1_q <= pins_d;
      sync2_q <= sync1_q;
    end
  end

  assign {s_clock_s, s_data_s, s_load_s, p_load_n_s, m_s, n_s, oe_s,
          sel_s, xtal_s, alt_s} = sync2_q;

  assign ref_s = sel_s ? xtal_s : alt_s;
  assign ref_rise = ref_s && !ref_prev_q;

  // Reference prescaler feeding the phase compare
  scfg_div #(
    .DIV(`SCFG_REF_PRESCALE),
    .W(5)
  ) u_prescale (
    .aclk(aclk),
    .aresetn(aresetn),
    .tick_in(ref_rise),
    .tick_out(cmp_tick),
    .toggle_out(cmp_tog)
  );

  // Shift register and configuration latches
  always_comb
  begin
    shift_d = shift_q;
    cfg_d = cfg_q;
    if (s_clock_s && !sclk_prev_q)
      shift_d = {shift_q[`SCFG_WORD_W-2:0], s_data_s};
    if (s_load_s)
      cfg_d = scfg_word_s'(shift_q);
    else if (sload_prev_q)
      cfg_d = scfg_word_s'(shift_q);
    if (!p_load_n_s || !pload_prev_q)
    begin
      // Low: transparent; first high sample: captured
      cfg_d.fbdiv = m_s;
      cfg_d.post = n_s;
    end
  end

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      sclk_prev_q <= 1'b0;
      sload_prev_q <= 1'b0;
      pload_prev_q <= 1'b0;
      ref_prev_q <= 1'b0;
      shift_q <= '0;
      cfg_q <= {`SCFG_RST_T, `SCFG_RST_N, `SCFG_RST_M};
    end
    else
    begin
      sclk_prev_q <= s_clock_s;
      sload_prev_q <= s_load_s;
      pload_prev_q <= p_load_n_s;
      ref_prev_q <= ref_s;
      shift_q <= shift_d;
      cfg_q <= cfg_d;
    end
  end

  // Post-divider code to oscillator half-periods per output half-period
  always_comb
  begin
    case (cfg_q.post)
      `SCFG_N_DIV2: ratio = `SCFG_RATIO_W'(2);
      `SCFG_N_DIV4: ratio = `SCFG_RATIO_W'(4);
      `SCFG_N_DIV8: ratio = `SCFG_RATIO_W'(8);
      default: ratio = `SCFG_RATIO_W'(1);
    endcase
  end

  assign vco_tick = (credit_q != '0);

  // Oscillator model, post-divider, output gate and probe
  always_comb
  begin
    credit_d = credit_q;
    if (vco_tick)
      credit_d = credit_q - `SCFG_CREDIT_W'(1);
    if (cmp_tick)
    begin
      // Each compare period reloads 8*M half-periods, no backlog
      credit_d = `SCFG_CREDIT_W'(cfg_q.fbdiv)
                 * `SCFG_CREDIT_W'(`SCFG_HALF_PER_M);
    end
    half_cnt_d = half_cnt_q;
    raw_d = raw_q;
    if (half_cnt_q >= ratio)
      half_cnt_d = '0;
    else if (vco_tick)
    begin
      if (half_cnt_q + `SCFG_RATIO_W'(1) >= ratio)
      begin
        half_cnt_d = '0;
        raw_d = ~raw_q;
      end
      else
        half_cnt_d = half_cnt_q + `SCFG_RATIO_W'(1);
    end
    gate_d = gate_q;
    if (!raw_d)
      gate_d = oe_s;
    fout_p_d = gate_d && raw_d;
    case (scfg_probe_e'(cfg_q.probe))
      SCFG_P_CMP: test_d = cmp_tog;
      SCFG_P_REF: test_d = ref_s;
      SCFG_P_VCO: test_d = vco_tick;
      SCFG_P_FOUT: test_d = raw_q;
      SCFG_P_GATE: test_d = gate_q;
      SCFG_P_SCLK: test_d = s_clock_s;
      default: test_d = 1'b0;
    endcase
  end

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      credit_q <= '0;
      half_cnt_q <= '0;
      raw_q <= 1'b0;
      gate_q <= 1'b0;
      link.fout_p <= 1'b0;
      link.fout_n <= 1'b1;
      link.test_out <= 1'b0;
    end
    else
    begin
      credit_q <= credit_d;
      half_cnt_q <= half_cnt_d;
      raw_q <= raw_d;
      gate_q <= gate_d;
      link.fout_p <= fout_p_d;
      link.fout_n <= ~fout_p_d;
      link.test_out <= test_d;
    end
  end
endmodule : scfg_dev

//--- design/scfg_host.sv
// Implementation choices: the address map and the AXI4-Lite register port.
`timescale 1ns/1ps
`include "scfg_regs.svh"
module scfg_host
  import scfg_pkg::*;
(
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic [3:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [3:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  scfg_link_if.host link
);
  logic aw_got_q, aw_got_d, w_got_q, w_got_d;
  logic [3:0] awaddr_q, awaddr_d;
  logic [31:0] wdata_q, wdata_d, wmask;
  logic awready_d, wready_d, bvalid_d, arready_d, rvalid_d;
  logic [1:0] bresp_d, rresp_d;
  logic [31:0] rdata_d;
  logic [2:0] ctrl_q, ctrl_d;
  logic [`SCFG_WORD_W-1:0] word_q, word_d, sh_q, sh_d;
  logic [3:0] bits_q, bits_d;
  scfg_hstate_e st_q, st_d;
  logic cmd_ser, cmd_par, step;
  logic sclk_d, sdat_d, sload_d, pload_d, drv_d;
  logic [`SCFG_WORD_W-1:0] out_d, out_q;
  logic pace_en;

  // Pacer idles between transfers holding a count of one, so after a transfer the next first step is one cycle short
  assign pace_en = (st_q != SCFG_H_IDLE);

  // Pacing of link steps, one half shift-clock period each
  scfg_div #(
    .DIV(`SCFG_SCLK_HALF_CYC),
    .W(4)
  ) u_pace (
    .aclk(aclk),
    .aresetn(aresetn),
    .tick_in(pace_en),
    .tick_out(step),
    .toggle_out()
  );

  // Register slave
  always_comb
  begin
    aw_got_d = aw_got_q;
    w_got_d = w_got_q;
    awaddr_d = awaddr_q;
    wdata_d = wdata_q;
    bvalid_d = s_axi_bvalid && !s_axi_bready;
    bresp_d = s_axi_bresp;
    ctrl_d = ctrl_q;
    word_d = word_q;
    cmd_ser = 1'b0;
    cmd_par = 1'b0;
    wmask = {{8{s_axi_wstrb[3]}}, {8{s_axi_wstrb[2]}},
             {8{s_axi_wstrb[1]}}, {8{s_axi_wstrb[0]}}};
    if (s_axi_awvalid && s_axi_awready)
    begin
      aw_got_d = 1'b1;
      awaddr_d = s_axi_awaddr;
    end
    if (s_axi_wvalid && s_axi_wready)
    begin
      w_got_d = 1'b1;
      wdata_d = (wdata_q & ~wmask) | (s_axi_wdata & wmask);
    end
    if (aw_got_q && w_got_q && !s_axi_bvalid)
    begin
      aw_got_d = 1'b0;
      w_got_d = 1'b0;
      bvalid_d = 1'b1;
      bresp_d = `SCFG_RESP_OKAY;
      case (awaddr_q)
        `SCFG_A_CTRL: ctrl_d = wdata_q[2:0];
        `SCFG_A_WORD: word_d = wdata_q[`SCFG_WORD_W-1:0];
        `SCFG_A_CMD:
        begin
          cmd_ser = wdata_q[`SCFG_CMD_SERIAL];
          cmd_par = wdata_q[`SCFG_CMD_PARALLEL] && !cmd_ser;
        end
        `SCFG_A_STATUS: bresp_d = `SCFG_RESP_SLVERR;
        default: bresp_d = `SCFG_RESP_SLVERR;
      endcase
    end
    awready_d = !aw_got_d && !bvalid_d;
    wready_d = !w_got_d && !bvalid_d;
    rvalid_d = s_axi_rvalid && !s_axi_rready;
    rdata_d = s_axi_rdata;
    rresp_d = s_axi_rresp;
    if (s_axi_arvalid && s_axi_arready)
    begin
      rvalid_d = 1'b1;
      rresp_d = `SCFG_RESP_OKAY;
      case (s_axi_araddr)
        `SCFG_A_CTRL: rdata_d = {29'h0, ctrl_q};
        `SCFG_A_WORD: rdata_d = {18'h0, word_q};
        `SCFG_A_CMD: rdata_d = 32'h0;
        `SCFG_A_STATUS: rdata_d = {24'h0, bits_q, 1'b0, st_q};
        default:
        begin
          rdata_d = 32'h0;
          rresp_d = `SCFG_RESP_SLVERR;
        end
      endcase
    end
    arready_d = !rvalid_d;
  end

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      aw_got_q <= 1'b0;
      w_got_q <= 1'b0;
      awaddr_q <= 4'h0;
      wdata_q <= 32'h0;
      s_axi_awready <= 1'b0;
      s_axi_wready <= 1'b0;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= 2'h0;
      s_axi_arready <= 1'b0;
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= 32'h0;
      s_axi_rresp <= 2'h0;
      ctrl_q <= `SCFG_RST_CTRL;
      word_q <= {`SCFG_RST_T, `SCFG_RST_N, `SCFG_RST_M};
    end
    else
    begin
      aw_got_q <= aw_got_d;
      w_got_q <= w_got_d;
      awaddr_q <= awaddr_d;
      wdata_q <= wdata_d;
      s_axi_awready <= awready_d;
      s_axi_wready <= wready_d;
      s_axi_bvalid <= bvalid_d;
      s_axi_bresp <= bresp_d;
      s_axi_arready <= arready_d;
      s_axi_rvalid <= rvalid_d;
      s_axi_rdata <= rdata_d;
      s_axi_rresp <= rresp_d;
      ctrl_q <= ctrl_d;
      word_q <= word_d;
    end
  end

  // Link sequencer
  always_comb
  begin
    st_d = st_q;
    sh_d = sh_q;
    bits_d = bits_q;
    sclk_d = link.s_clock;
    sdat_d = link.s_data;
    sload_d = link.s_load;
    pload_d = link.p_load_n;
    out_d = out_q;
    drv_d = link.m_oe;
    case (st_q)
      SCFG_H_IDLE:
        if (cmd_ser)
        begin
          sh_d = word_q;
          bits_d = 4'(`SCFG_WORD_W);
          sdat_d = word_q[`SCFG_WORD_W-1];
          st_d = SCFG_H_SH_LO;
        end
        else if (cmd_par)
        begin
          out_d = word_q;
          drv_d = ctrl_q[`SCFG_CTRL_PARDRV];
          pload_d = 1'b0;
          st_d = SCFG_H_PAR_LO;
        end
      SCFG_H_SH_LO:
        if (step)
        begin
          sclk_d = 1'b1;
          st_d = SCFG_H_SH_HI;
        end
      SCFG_H_SH_HI:
        if (step)
        begin
          sclk_d = 1'b0;
          sh_d = {sh_q[`SCFG_WORD_W-2:0], 1'b0};
          bits_d = bits_q - 4'h1;
          sdat_d = sh_q[`SCFG_WORD_W-2];
          if (bits_q == 4'h1)
          begin
            sload_d = 1'b1;
            st_d = SCFG_H_LD_HI;
          end
          else
            st_d = SCFG_H_SH_LO;
        end
      SCFG_H_LD_HI:
        if (step)
        begin
          sload_d = 1'b0;
          st_d = SCFG_H_LD_LO;
        end
      SCFG_H_LD_LO:
        if (step)
          st_d = SCFG_H_IDLE;
      SCFG_H_PAR_LO:
        if (step)
        begin
          pload_d = 1'b1;
          st_d = SCFG_H_PAR_HI;
        end
      SCFG_H_PAR_HI:
        if (step)
          st_d = SCFG_H_IDLE;
      default: st_d = SCFG_H_IDLE;
    endcase
  end

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      st_q <= SCFG_H_PAR_LO;
      sh_q <= '0;
      bits_q <= 4'h0;
      out_q <= '0;
      link.s_clock <= 1'b0;
      link.s_data <= 1'b0;
      link.s_load <= 1'b0;
      link.p_load_n <= 1'b0;
      link.m_oe <= 1'b0;
      link.n_oe <= 1'b0;
      link.m_drv <= '0;
      link.n_drv <= '0;
      link.oe <= 1'b0;
      link.ref_source_select <= 1'b1;
    end
    else
    begin
      st_q <= st_d;
      sh_q <= sh_d;
      bits_q <= bits_d;
      out_q <= out_d;
      link.s_clock <= sclk_d;
      link.s_data <= sdat_d;
      link.s_load <= sload_d;
      link.p_load_n <= pload_d;
      link.m_oe <= drv_d;
      link.n_oe <= drv_d;
      link.m_drv <= out_d[`SCFG_N_LSB-1:`SCFG_M_LSB];
      link.n_drv <= out_d[`SCFG_T_LSB-1:`SCFG_N_LSB];
      link.oe <= ctrl_q[`SCFG_CTRL_OE];
      link.ref_source_select <= ctrl_q[`SCFG_CTRL_REFSEL];
    end
  end
endmodule : scfg_host

//--- test/scfg_link_sva.sv
`timescale 1ns/1ps
module scfg_link_sva (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic s_clock,
  input wire logic s_data,
  input wire logic s_load,
  input wire logic p_load_n,
  input wire logic [8:0] m_pin,
  input wire logic [1:0] n_pin,
  input wire logic oe,
  input wire logic fout_p,
  input wire logic fout_n
);
  default clocking cb @(posedge aclk);
  endclocking
  default disable iff (!aresetn);

  // Cycles with the output gate low, saturating
  logic [6:0] off_q;
  logic [6:0] off_d;
  always_comb
  begin
    off_d = oe ? 7'h0 : off_q + {6'h0, off_q != 7'h7f};
  end
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
      off_q <= 7'h0;
    else
      off_q <= off_d;
  end

  a_diff_pair: assert property (fout_n == !fout_p)
    else $error("output pair not complementary");
  a_stop_low: assert property (off_q >= 7'h60 |-> !fout_p && fout_n)
    else $error("output not parked low while disabled");
  a_shift_hold: assert property (s_clock && $past(s_clock) |-> $stable(s_data))
    else $error("serial data moved while shift clock high");
  a_load_quiet: assert property (s_load && $past(s_load)
    |-> !s_clock && $stable(s_data))
    else $error("serial word moved during latch strobe");
  a_load_pulse: assert property ($rose(s_load)
    |-> s_load[*3] ##[1:2] !s_load)
    else $error("serial latch strobe of wrong length");
  a_par_pulse: assert property ($fell(p_load_n)
    |-> !p_load_n[*3] ##[1:2] p_load_n)
    else $error("parallel strobe of wrong length");
  a_par_hold: assert property ($rose(p_load_n)
    |-> $stable(m_pin) && $stable(n_pin))
    else $error("divider pins moved at parallel capture");
  a_par_first: assert property (!p_load_n |-> !s_load && !s_clock)
    else $error("serial activity during parallel load");

  c_serial: cover property ($fell(s_load));
  c_parallel: cover property ($rose(p_load_n));
  c_parked: cover property (off_q == 7'h60);
endmodule : scfg_link_sva

//--- test/synth_divider_config_logic_test.sv
`timescale 1ns/1ps
module synth_divider_config_logic_test
  import scfg_pkg::*;
;
  typedef struct packed {
    logic [3:0] a;
    logic [31:0] wd;
    logic [31:0] rd;
    logic [1:0] wr;
    logic [1:0] rr;
  } scfg_row_s;
  scfg_row_s rows[6] = '{'{4'h0, 32'h3, 32'h3, 2'h0, 2'h0},
    '{4'h4, 32'hffffffff, 32'h3fff, 2'h0, 2'h0},
    '{4'h4, 32'h7ff, 32'h7ff, 2'h0, 2'h0},
    '{4'h8, 32'h0, 32'h0, 2'h0, 2'h0},
    '{4'hc, 32'hff, 32'h0, 2'h2, 2'h0},
    '{4'h2, 32'h1, 32'h0, 2'h2, 2'h2}};
  int rt[4] = '{2, 4, 8, 1};
  logic aclk = 1'b0, aresetn = 1'b0, xtal = 1'b0, alt_ref = 1'b0;
  logic [3:0] awaddr = 4'h0, araddr = 4'h0;
  logic [31:0] wdata = 32'h0;
  logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0;
  logic arvalid = 1'b0, rready = 1'b0;
  logic awready, wready, bvalid, arready, rvalid;
  logic [1:0] bresp, rresp;
  logic [31:0] rdata;
  logic sc_q = 1'b0, sl_q = 1'b0;
  logic [13:0] sh = 14'h0, cap = 14'h0;
  int nb = 0, nb_cap = 0, err_count = 0, check_count = 0;

  always #50 aclk = ~aclk;
  always #200 xtal = ~xtal;

  scfg_link_if link ();
  scfg_host scfg_host_inst (.aclk(aclk), .aresetn(aresetn),
    .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
    .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(4'hf),
    .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp),
    .s_axi_bvalid(bvalid), .s_axi_bready(bready), .s_axi_araddr(araddr),
    .s_axi_arvalid(arvalid), .s_axi_arready(arready),
    .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid),
    .s_axi_rready(rready), .link(link.host));
  scfg_dev scfg_dev_inst (.aclk(aclk), .aresetn(aresetn),
    .xtal_clk_in(xtal), .alt_ref_clock_in(alt_ref), .link(link.dev));
  scfg_link_sva scfg_link_sva_inst (.aclk(aclk), .aresetn(aresetn),
    .s_clock(link.s_clock), .s_data(link.s_data), .s_load(link.s_load),
    .p_load_n(link.p_load_n), .m_pin(link.m_pin), .n_pin(link.n_pin),
    .oe(link.oe), .fout_p(link.fout_p), .fout_n(link.fout_n));

  // Rebuild the shifted word from the wire
  always @(posedge aclk)
  begin
    sc_q <= link.s_clock;
    sl_q <= link.s_load;
    if (link.s_clock && !sc_q)
    begin
      sh <= {sh[12:0], link.s_data};
      nb <= nb + 1;
    end
    if (!link.s_load && sl_q)
    begin
      cap <= sh;
      nb_cap <= nb;
      nb <= 0;
    end
  end

  task automatic final_report;
    $display("checks %0d errors %0d", check_count, err_count);
    if (err_count == 0 && check_count > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask : final_report

  task automatic chk_val(input string nm, input logic [31:0] e, g);
    check_count++;
    if (g !== e)
    begin
      err_count++;
      $display("wrong value %s expected %h seen %h", nm, e, g);
    end
  endtask : chk_val

  task automatic chk_cnt(input string nm, input int e, t, g);
    check_count++;
    if (g < e - t || g > e + t)
    begin
      err_count++;
      $display("wrong value %s expected %0d seen %0d", nm, e, g);
    end
  endtask : chk_cnt

  task automatic wr(input logic [3:0] a, input logic [31:0] d,
    output logic [1:0] r);
    @(posedge aclk);
    awaddr <= a;
    wdata <= d;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    forever
    begin
      @(posedge aclk);
      if (awready)
        awvalid <= 1'b0;
      if (wready)
        wvalid <= 1'b0;
      if (bvalid)
        break;
    end
    r = bresp;
    bready <= 1'b0;
  endtask : wr

  task automatic rd(input logic [3:0] a, output logic [31:0] d,
    output logic [1:0] r);
    @(posedge aclk);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    forever
    begin
      @(posedge aclk);
      if (arready)
        arvalid <= 1'b0;
      if (rvalid)
        break;
    end
    d = rdata;
    r = rresp;
    rready <= 1'b0;
  endtask : rd

  task automatic cfg(input logic [31:0] c, w, input logic [1:0] k);
    logic [1:0] r;
    logic [31:0] d;
    wr(4'h0, c, r);
    wr(4'h4, w, r);
    wr(4'h8, {30'h0, k}, r);
    repeat (2) @(posedge aclk);
    d = 32'h1;
    while (d[2:0] !== 3'h0)
      rd(4'hc, d, r);
    repeat (8) @(posedge aclk);
  endtask : cfg

  task automatic count_tog(output int c);
    logic p;
    c = 0;
    p = link.fout_p;
    repeat (640)
    begin
      @(posedge aclk);
      if (link.fout_p !== p)
        c++;
      p = link.fout_p;
    end
  endtask : count_tog

  initial
  begin
    logic [1:0] r;
    logic [31:0] d;
    int c;
    repeat (2) @(posedge aclk);
    aresetn <= 1'b1;
    repeat (12) @(posedge aclk);
    foreach (rows[i])
    begin
      wr(rows[i].a, rows[i].wd, r);
      chk_val("write response", {30'h0, rows[i].wr}, {30'h0, r});
      rd(rows[i].a, d, r);
      chk_val("read response", {30'h0, rows[i].rr}, {30'h0, r});
      if (rows[i].rr == 2'h0)
        chk_val("read data", rows[i].rd, d);
    end
    cfg(32'h3, 32'h2e02, 2'h1);
    chk_val("shifted word", 32'h2e02, {18'h0, cap});
    chk_cnt("shift count", 14, 0, nb_cap);
    repeat (40) @(posedge aclk);
    chk_val("probe gate", 32'h1, {31'h0, link.test_out});
    repeat (80) @(posedge aclk);
    count_tog(c);
    chk_cnt("serial toggles", 160, 18, c);
    for (int i = 0; i < 4; i++)
    begin
      cfg(32'h7, {21'h0, i[1:0], 9'h2}, 2'h2);
      repeat (120) @(posedge aclk);
      count_tog(c);
      chk_cnt("post divider", 160 / rt[i], 16 / rt[i] + 2, c);
    end
    wr(4'h0, 32'h5, r);
    repeat (200) @(posedge aclk);
    count_tog(c);
    chk_cnt("alt ref toggles", 0, 0, c);
    wr(4'h0, 32'h7, r);
    repeat (128) @(posedge aclk);
    count_tog(c);
    chk_cnt("xtal toggles", 160, 18, c);
    cfg(32'h3, 32'h0, 2'h2);
    chk_val("m pullup", 32'h1ff, {23'h0, link.m_pin});
    chk_val("n pullup", 32'h3, {30'h0, link.n_pin});
    repeat (128) @(posedge aclk);
    count_tog(c);
    chk_cnt("pullup toggles", 640, 4, c);
    cfg(32'h3, 32'h0602, 2'h1);
    repeat (40) @(posedge aclk);
    chk_val("probe quiet", 32'h0, {31'h0, link.test_out});
    wr(4'h0, 32'h2, r);
    repeat (96) @(posedge aclk);
    chk_val("parked pair", 32'h1, {30'h0, link.fout_p, link.fout_n});
    count_tog(c);
    chk_cnt("gated toggles", 0, 0, c);
    aresetn <= 1'b0;
    repeat (2) @(posedge aclk);
    @(negedge aclk);
    chk_val("reset outputs", 32'h2,
      {29'h0, link.fout_p, link.fout_n, link.test_out});
    @(posedge aclk);
    aresetn <= 1'b1;
    rd(4'h0, d, r);
    chk_val("ctrl reset", 32'h3, d);
    rd(4'h4, d, r);
    chk_val("word reset", 32'h7ff, d);
    repeat (200) @(posedge aclk);
    count_tog(c);
    chk_cnt("default toggles", 640, 4, c);
    final_report();
  end

  initial
  begin
    repeat (40000) @(posedge aclk);
    err_count++;
    final_report();
  end
endmodule : synth_divider_config_logic_test
